/* File: verilog/lpic_pkg.sv */
`default_nettype none

package lpic_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_SCL_LOW = 12'h000;
	localparam logic [11:0] OFS_CTRL = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_TIMEOUT = 12'h00c;
	localparam logic [11:0] OFS_SCL_HIGH = 12'h014;
	localparam logic [11:0] OFS_SDA_DUTY = 12'h018;
	localparam logic [11:0] OFS_START_WAIT = 12'h01c;
	localparam logic [11:0] OFS_STOP_WAIT = 12'h020;
	localparam logic [11:0] OFS_EVT_CLR = 12'h024;
	localparam logic [11:0] OFS_EVT_RAW = 12'h028;
	localparam logic [11:0] OFS_EVT_ST = 12'h02c;
	localparam logic [11:0] OFS_EVT_ENA = 12'h030;
	localparam logic [11:0] OFS_RDATA = 12'h034;
	localparam logic [11:0] OFS_CMD0 = 12'h038;
	localparam logic [11:0] OFS_XFER_CTRL = 12'h058;
	localparam logic [11:0] OFS_TGT0 = 12'h080;
	localparam logic [11:0] OFS_PIN_ROUTE = 12'h090;

	// ****************************************
	// Field positions and sizes
	// ****************************************
	localparam logic [2:0] NUM_CMD = 3'd7;
	localparam logic [2:0] NUM_WR_CMD = 3'd2;
	localparam int NUM_EVT = 9;
	localparam int CTRL_MASTER_BIT = 0;
	localparam int CMD_SLOT_LSB = 8;
	localparam int CMD_DONE_BIT = 31;
	localparam int XC_REG_LSB = 11;
	localparam int XC_DATA_LSB = 19;
	localparam int XC_START_BIT = 27;
	localparam int XC_FORCE_BIT = 28;
	localparam int TGT_HI_LSB = 11;
	localparam int ROUTE_SDA_LSB = 2;

	// Event numbering in the raw register
	localparam int EV_SLAVE_DONE = 0;
	localparam int EV_ARB_LOST = 1;
	localparam int EV_MASTER_DONE = 2;
	localparam int EV_STOP_SEEN = 3;
	localparam int EV_TIMEOUT = 4;
	localparam int EV_ACK_ERR = 5;
	localparam int EV_RX_DATA = 6;
	localparam int EV_TX_DATA = 7;
	localparam int EV_START_SEEN = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_SCL_LOW = 16'h0028;
	localparam logic [15:0] RST_SCL_HIGH = 16'h0028;
	localparam logic [15:0] RST_SDA_DUTY = 16'h0010;
	localparam logic [15:0] RST_START_WAIT = 16'h001e;
	localparam logic [15:0] RST_STOP_WAIT = 16'h002c;
	localparam logic [19:0] RST_TIMEOUT = 20'h000c8;
	localparam logic [3:0] RST_ROUTE = 4'h4;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [15:0] scl_low;
		logic [15:0] scl_high;
		logic [15:0] sda_duty;
		logic [15:0] start_wait;
		logic [15:0] stop_wait;
		logic [19:0] timeout;
	} lpic_timing_s;

	typedef enum logic [2:0] {
		BUS_IDLE, BUS_START, BUS_LOW, BUS_HIGH, BUS_RS_LOW, BUS_RS_HIGH, BUS_STOP_LOW,
		BUS_STOP_HIGH
	} lpic_bus_e;

	typedef enum logic [1:0] {
		STEP_ADDR_W, STEP_REG, STEP_ADDR2, STEP_DATA
	} lpic_step_e;

endpackage : lpic_pkg

`default_nettype wire

/* File: verilog/lpic_top.sv */
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lpic_top
	import lpic_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [11:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output var logic [31:0] RDATA,
	input wire logic [3:0] PIN_IN,
	output var logic [3:0] PIN_OUT,
	output var logic [3:0] PIN_OE
);

	// ****************************************
	// Declarations
	// ****************************************
	lpic_timing_s tim_reg;
	logic master_mode_reg;
	logic [31:0] xfer_ctrl_reg;
	logic [3:0] route_reg;
	logic [6:0] tgt_reg [0:7];
	logic [10:0] cmd_reg [0:7];
	logic [6:0] cmd_done_reg;
	logic [8:0] raw_reg;
	logic [8:0] ena_reg;
	logic [7:0] rdata_reg;
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	logic scl_prev_reg, sda_prev_reg, go_prev_reg;
	lpic_bus_e state_reg, state_next;
	lpic_step_e step_reg, step_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] bit_reg, bit_next;
	logic [8:0] sh_reg, sh_next;
	logic [7:0] rx_reg, rx_next;
	logic [7:0] bc_reg, bc_next;
	logic [2:0] idx_reg, idx_next;
	logic run_reg, run_next;
	logic scl_low_reg, scl_low_next;
	logic sda_low_reg, sda_low_next;
	logic [19:0] to_cnt_reg;
	logic [8:0] ev_reg, ev_next;
	logic [7:0] rdata_next;
	logic cmd_fin;
	logic [31:0] rd_mux;
	logic [3:0] oe_next;

	function automatic logic low_done(input logic [15:0] cnt, input logic [15:0] lim,
		input logic [15:0] duty);
		low_done = (cnt >= lim) && (cnt > duty);
	endfunction : low_done

	// ****************************************
	// Decoding
	// ****************************************
	wire [11:0] cmd_off = ADDR - OFS_CMD0;
	wire [2:0] cmd_sel = cmd_off[4:2];
	wire cmd_hit = (cmd_off[11:5] == 7'h00) && (cmd_off[1:0] == 2'h0) && (cmd_sel != NUM_CMD);
	wire [11:0] tgt_off = ADDR - OFS_TGT0;
	wire [1:0] tgt_sel = tgt_off[3:2];
	wire tgt_hit = (tgt_off[11:4] == 8'h00) && (tgt_off[1:0] == 2'h0);
	wire scl_in = pin_sync_reg[route_reg[1:0]];
	wire sda_in = pin_sync_reg[route_reg[3:2]];
	wire [10:0] cur_cmd = cmd_reg[idx_reg];
	wire [7:0] cur_bytes = cur_cmd[7:0];
	wire [6:0] cur_tgt = tgt_reg[cur_cmd[10:8]];
	wire is_read = idx_reg >= NUM_WR_CMD;
	wire [7:0] reg_fld = xfer_ctrl_reg[XC_REG_LSB +: 8];
	wire [7:0] wdata_fld = xfer_ctrl_reg[XC_DATA_LSB +: 8];
	wire go = xfer_ctrl_reg[XC_START_BIT] & xfer_ctrl_reg[XC_FORCE_BIT];
	wire go_take = go & ~go_prev_reg & master_mode_reg & (state_reg == BUS_IDLE) & ~run_reg;
	wire rx_phase = (step_reg == STEP_DATA) && is_read;
	wire wr_load = (step_reg == STEP_DATA) && !is_read && (bit_reg == 4'd0);
	wire tx_bit = wr_load ? wdata_fld[7] : sh_reg[8];
	wire scl_edge = scl_in ^ scl_prev_reg;
	wire start_seen = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
	wire stop_seen = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
	wire [7:0] bc_inc = bc_reg + 8'd1;
	wire [8:0] clr_vec = (WR && ADDR == OFS_EVT_CLR) ? WDATA[NUM_EVT:1] : 9'h000;
	wire [8:0] st_vec = raw_reg & ena_reg;

	// ****************************************
	// Bus sequencer
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		step_next = step_reg;
		cnt_next = cnt_reg + 16'd1;
		bit_next = bit_reg;
		sh_next = sh_reg;
		rx_next = rx_reg;
		bc_next = bc_reg;
		idx_next = idx_reg;
		run_next = run_reg;
		scl_low_next = scl_low_reg;
		sda_low_next = sda_low_reg;
		ev_next = 9'h000;
		rdata_next = rdata_reg;
		cmd_fin = 1'b0;
		case (state_reg)
			BUS_IDLE:
			begin
				cnt_next = 16'd0;
				scl_low_next = 1'b0;
				sda_low_next = 1'b0;
				if (go_take)
				begin
					run_next = 1'b1;
					idx_next = 3'd0;
				end
				else if (run_reg)
				begin
					if (idx_reg == NUM_CMD)
						run_next = 1'b0;
					else if (cur_bytes == 8'd0)
						idx_next = idx_reg + 3'd1;
					else
					begin
						state_next = BUS_START;
						sda_low_next = 1'b1;
						step_next = STEP_ADDR_W;
						sh_next = {cur_tgt, 1'b0, 1'b1};
						bc_next = 8'd0;
					end
				end
			end
			BUS_START:
			begin
				if (cnt_reg >= tim_reg.start_wait)
				begin
					scl_low_next = 1'b1;
					state_next = BUS_LOW;
					cnt_next = 16'd0;
					bit_next = 4'd0;
				end
			end
			BUS_LOW:
			begin
				if (cnt_reg == tim_reg.sda_duty)
				begin
					sda_low_next = ~tx_bit;
					if (wr_load)
						sh_next = {wdata_fld, 1'b1};
				end
				if (low_done(cnt_reg, tim_reg.scl_low, tim_reg.sda_duty))
				begin
					scl_low_next = 1'b0;
					state_next = BUS_HIGH;
					cnt_next = 16'd0;
				end
			end
			BUS_HIGH:
			begin
				if (!scl_in)
					cnt_next = 16'd0;
				else if (cnt_reg >= tim_reg.scl_high)
				begin
					scl_low_next = 1'b1;
					state_next = BUS_LOW;
					cnt_next = 16'd0;
					bit_next = bit_reg + 4'd1;
					sh_next = {sh_reg[7:0], 1'b1};
					if (bit_reg < 4'd8)
						rx_next = {rx_reg[6:0], sda_in};
					if (bit_reg < 4'd8 && !rx_phase && !sda_low_reg && !sda_in)
					begin
						ev_next[EV_ARB_LOST] = 1'b1;
						state_next = BUS_IDLE;
						run_next = 1'b0;
						scl_low_next = 1'b0;
					end
					else if (bit_reg == 4'd8 && !rx_phase && sda_in)
					begin
						ev_next[EV_ACK_ERR] = 1'b1;
						idx_next = NUM_CMD;
						state_next = BUS_STOP_LOW;
					end
					else if (bit_reg == 4'd8)
					begin
						bit_next = 4'd0;
						case (step_reg)
							STEP_ADDR_W:
							begin
								step_next = STEP_REG;
								sh_next = {reg_fld, 1'b1};
							end
							STEP_REG:
							begin
								step_next = STEP_ADDR2;
								state_next = BUS_RS_LOW;
								sh_next = {cur_tgt, is_read, 1'b1};
							end
							STEP_ADDR2:
							begin
								step_next = STEP_DATA;
								sh_next = {8'hff, cur_bytes == 8'd1};
							end
							default:
							begin
								bc_next = bc_inc;
								if (is_read)
								begin
									rdata_next = rx_reg;
									ev_next[EV_RX_DATA] = 1'b1;
									sh_next = {8'hff, (bc_inc + 8'd1) == cur_bytes};
								end
								else
									ev_next[EV_TX_DATA] = 1'b1;
								if (bc_inc == cur_bytes)
								begin
									cmd_fin = 1'b1;
									idx_next = idx_reg + 3'd1;
									state_next = BUS_STOP_LOW;
								end
							end
						endcase
					end
				end
			end
			BUS_RS_LOW:
			begin
				if (cnt_reg == tim_reg.sda_duty)
					sda_low_next = 1'b0;
				if (low_done(cnt_reg, tim_reg.scl_low, tim_reg.sda_duty))
				begin
					scl_low_next = 1'b0;
					state_next = BUS_RS_HIGH;
					cnt_next = 16'd0;
				end
			end
			BUS_RS_HIGH:
			begin
				if (!scl_in)
					cnt_next = 16'd0;
				else if (cnt_reg >= tim_reg.scl_high)
				begin
					sda_low_next = 1'b1;
					state_next = BUS_START;
					cnt_next = 16'd0;
				end
			end
			BUS_STOP_LOW:
			begin
				if (cnt_reg == tim_reg.sda_duty)
					sda_low_next = 1'b1;
				if (low_done(cnt_reg, tim_reg.scl_low, tim_reg.sda_duty))
				begin
					scl_low_next = 1'b0;
					state_next = BUS_STOP_HIGH;
					cnt_next = 16'd0;
				end
			end
			BUS_STOP_HIGH:
			begin
				if (!scl_in)
					cnt_next = 16'd0;
				else if (cnt_reg >= tim_reg.stop_wait)
				begin
					sda_low_next = 1'b0;
					state_next = BUS_IDLE;
					ev_next[EV_MASTER_DONE] = 1'b1;
				end
			end
			default:
				state_next = BUS_IDLE;
		endcase
		if (state_reg != BUS_IDLE && to_cnt_reg >= tim_reg.timeout)
		begin
			ev_next = 9'h000;
			ev_next[EV_TIMEOUT] = 1'b1;
			cmd_fin = 1'b0;
			state_next = BUS_IDLE;
			run_next = 1'b0;
			scl_low_next = 1'b0;
			sda_low_next = 1'b0;
		end
		ev_next[EV_START_SEEN] = start_seen;
		ev_next[EV_STOP_SEEN] = stop_seen;
		ev_next[EV_SLAVE_DONE] = stop_seen & (state_reg == BUS_IDLE) & ~run_reg;
	end

	// ****************************************
	// Pin routing and read mux
	// ****************************************
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			oe_next[i] = (route_reg[1:0] == i[1:0] && scl_low_reg) ||
				(route_reg[3:2] == i[1:0] && sda_low_reg);
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (ADDR)
			OFS_SCL_LOW: rd_mux = {16'h0000, tim_reg.scl_low};
			OFS_SCL_HIGH: rd_mux = {16'h0000, tim_reg.scl_high};
			OFS_SDA_DUTY: rd_mux = {16'h0000, tim_reg.sda_duty};
			OFS_START_WAIT: rd_mux = {16'h0000, tim_reg.start_wait};
			OFS_STOP_WAIT: rd_mux = {16'h0000, tim_reg.stop_wait};
			OFS_TIMEOUT: rd_mux = {12'h000, tim_reg.timeout};
			OFS_CTRL: rd_mux = {31'h0000_0000, master_mode_reg};
			OFS_STATUS: rd_mux = {24'h00_0000, idx_reg, state_reg, run_reg, state_reg != BUS_IDLE};
			OFS_EVT_RAW: rd_mux = {23'h00_0000, raw_reg};
			OFS_EVT_ENA: rd_mux = {22'h00_0000, ena_reg, 1'b0};
			OFS_EVT_ST: rd_mux = {22'h00_0000, st_vec, 1'b0};
			OFS_RDATA: rd_mux = {24'h00_0000, rdata_reg};
			OFS_XFER_CTRL: rd_mux = xfer_ctrl_reg;
			OFS_PIN_ROUTE: rd_mux = {28'h000_0000, route_reg};
			default:
			begin
				if (cmd_hit)
					rd_mux = {cmd_done_reg[cmd_sel], 20'h0_0000, cmd_reg[cmd_sel]};
				else if (tgt_hit)
					rd_mux = {14'h0000, tgt_reg[{tgt_sel, 1'b0}], 4'h0, tgt_reg[{tgt_sel, 1'b1}]};
			end
		endcase
	end

	// ****************************************
	// Engine registers
	// ****************************************
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg <= BUS_IDLE;
			step_reg <= STEP_ADDR_W;
			cnt_reg <= 16'd0;
			bit_reg <= 4'd0;
			sh_reg <= 9'h1ff;
			rx_reg <= 8'h00;
			bc_reg <= 8'h00;
			idx_reg <= 3'd0;
			run_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			ev_reg <= 9'h000;
			rdata_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			step_reg <= step_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			rx_reg <= rx_next;
			bc_reg <= bc_next;
			idx_reg <= idx_next;
			run_reg <= run_next;
			scl_low_reg <= scl_low_next;
			sda_low_reg <= sda_low_next;
			ev_reg <= ev_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			pin_meta_reg <= 4'hf;
			pin_sync_reg <= 4'hf;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			go_prev_reg <= 1'b0;
			to_cnt_reg <= 20'h00000;
			PIN_OE <= 4'h0;
			PIN_OUT <= 4'h0;
			RDATA <= 32'h0000_0000;
		end
		else
		begin
			pin_meta_reg <= PIN_IN;
			pin_sync_reg <= pin_meta_reg;
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
			go_prev_reg <= go;
			to_cnt_reg <= (state_reg == BUS_IDLE || scl_edge) ? 20'h00000 : to_cnt_reg + 20'h00001;
			PIN_OE <= oe_next;
			PIN_OUT <= 4'h0;
			RDATA <= RD ? rd_mux : 32'h0000_0000;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			tim_reg <= {RST_SCL_LOW, RST_SCL_HIGH, RST_SDA_DUTY, RST_START_WAIT, RST_STOP_WAIT,
				RST_TIMEOUT};
			master_mode_reg <= 1'b0;
			xfer_ctrl_reg <= 32'h0000_0000;
			route_reg <= RST_ROUTE;
			raw_reg <= 9'h000;
			ena_reg <= 9'h000;
			cmd_done_reg <= 7'h00;
			for (int i = 0; i < 8; i++)
			begin
				tgt_reg[i] <= 7'h00;
				cmd_reg[i] <= 11'h000;
			end
		end
		else
		begin
			raw_reg <= (raw_reg & ~clr_vec) | ev_reg;
			if (go_take)
				cmd_done_reg <= 7'h00;
			else if (cmd_fin)
				cmd_done_reg[idx_reg] <= 1'b1;
			if (WR)
			begin
				case (ADDR)
					OFS_SCL_LOW: tim_reg.scl_low <= WDATA[15:0];
					OFS_SCL_HIGH: tim_reg.scl_high <= WDATA[15:0];
					OFS_SDA_DUTY: tim_reg.sda_duty <= WDATA[15:0];
					OFS_START_WAIT: tim_reg.start_wait <= WDATA[15:0];
					OFS_STOP_WAIT: tim_reg.stop_wait <= WDATA[15:0];
					OFS_TIMEOUT: tim_reg.timeout <= WDATA[19:0];
					OFS_CTRL: master_mode_reg <= WDATA[CTRL_MASTER_BIT];
					OFS_EVT_ENA: ena_reg <= WDATA[NUM_EVT:1];
					OFS_XFER_CTRL: xfer_ctrl_reg <= WDATA;
					OFS_PIN_ROUTE: route_reg <= WDATA[3:0];
					default:
					begin
						if (cmd_hit)
							cmd_reg[cmd_sel] <= WDATA[10:0];
						if (tgt_hit)
						begin
							tgt_reg[{tgt_sel, 1'b0}] <= WDATA[TGT_HI_LSB +: 7];
							tgt_reg[{tgt_sel, 1'b1}] <= WDATA[6:0];
						end
					end
				endcase
			end
		end
	end

endmodule : lpic_top

`default_nettype wire

/* File: tb/lpic_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module lpic_chk
	import lpic_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [11:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [3:0] PIN_IN,
	input wire logic [3:0] PIN_OUT,
	input wire logic [3:0] PIN_OE
);
	logic [15:0] high_q, duty_q, start_q, stop_q;
	logic [19:0] to_q, quiet;
	logic [3:0] route_q;
	logic mode_q, after_start;
	logic [31:0] low_cnt, high_cnt, st_cnt;
	wire logic scl_oe = PIN_OE[route_q[1:0]];
	wire logic sda_oe = PIN_OE[route_q[3:2]];
	wire logic scl_in = PIN_IN[route_q[1:0]];
	// ****************************************
	// Shadow of the settings software wrote
	// ****************************************
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			high_q <= RST_SCL_HIGH;
			duty_q <= RST_SDA_DUTY;
			start_q <= RST_START_WAIT;
			stop_q <= RST_STOP_WAIT;
			to_q <= RST_TIMEOUT;
			route_q <= RST_ROUTE;
			mode_q <= 1'b0;
		end
		else if (WR)
			case (ADDR)
				OFS_SCL_HIGH: high_q <= WDATA[15:0];
				OFS_SDA_DUTY: duty_q <= WDATA[15:0];
				OFS_START_WAIT: start_q <= WDATA[15:0];
				OFS_STOP_WAIT: stop_q <= WDATA[15:0];
				OFS_TIMEOUT: to_q <= WDATA[19:0];
				OFS_PIN_ROUTE: route_q <= WDATA[3:0];
				OFS_CTRL: mode_q <= WDATA[0];
				default: ;
			endcase
	// ****************************************
	// Phase counters on the wire
	// ****************************************
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			low_cnt <= '0;
			high_cnt <= '0;
			st_cnt <= '0;
			after_start <= 1'b0;
			quiet <= '0;
		end
		else
		begin
			low_cnt <= scl_oe ? low_cnt + 32'd1 : 32'd0;
			high_cnt <= scl_oe ? 32'd0 : high_cnt + 32'd1;
			st_cnt <= ($rose(sda_oe) && !scl_oe) ? 32'd0 : st_cnt + 32'd1;
			after_start <= ($rose(sda_oe) && !scl_oe) || (after_start && !$rose(scl_oe));
			quiet <= (PIN_OE == 4'h0 || $changed(scl_in)) ? 20'd0 : quiet + 20'd1;
		end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	out_low_a: assert property (PIN_OUT == 4'h0)
		else $error("pin output value not zero");
	pin_route_a: assert property ((PIN_OE & ~(4'h1 << route_q[1:0]) & ~(4'h1 << route_q[3:2])) == 4'h0)
		else $error("unrouted pin driven");
	mode_gate_a: assert property (!mode_q |-> PIN_OE == 4'h0)
		else $error("lines driven outside master mode");
	sda_hold_a: assert property ($rose(sda_oe) && $past(scl_oe) && scl_oe |-> low_cnt + 32'd1 >= {16'h0, duty_q})
		else $error("data changed too soon after clock fell");
	high_width_a: assert property ($rose(scl_oe) |-> high_cnt >= {16'h0, high_q})
		else $error("clock high phase too short");
	start_wait_a: assert property ($rose(scl_oe) && after_start |-> st_cnt >= {16'h0, start_q})
		else $error("start hold too short");
	stop_wait_a: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> high_cnt >= {16'h0, stop_q})
		else $error("stop wait too short");
	bus_quiet_a: assert property (quiet <= to_q + 20'd8)
		else $error("lines held past the timeout");
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data outside read cycle");
endmodule : lpic_chk
bind lpic_top lpic_chk chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
`default_nettype wire

/* File: tb/lpic_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module lpic_slave
#(
	parameter logic [6:0] OWN_ADDR = 7'h2a
)
(
	input wire logic scl,
	input wire logic sda,
	output var logic sda_oe
);
	logic [7:0] sh, tx;
	logic [7:0] rxq [$];
	int bitn = 99, nb = 0, n_tx = 0;
	logic rd = 1'b0, tx_on = 1'b0;
	initial sda_oe = 1'b0;
	always @(negedge sda)
		if (scl)
		begin
			bitn = -1;
			nb = 0;
			rd = 1'b0;
			tx_on = 1'b0;
		end
	always @(posedge sda)
		if (scl)
		begin
			bitn = 99;
			tx_on = 1'b0;
		end
	always @(posedge scl)
		if (bitn >= 0 && bitn < 8)
			sh = {sh[6:0], sda};
		else if (bitn == 8 && tx_on && sda)
			tx_on = 1'b0;
	always @(negedge scl)
		if (bitn < 9)
		begin
			bitn = bitn + 1;
			if (bitn == 9)
			begin
				bitn = 0;
				if (!rd)
					rxq.push_back(sh);
				if (!rd && nb == 0 && sh == {OWN_ADDR, 1'b1})
				begin
					rd = 1'b1;
					tx_on = 1'b1;
				end
				if (tx_on)
				begin
					tx = 8'ha5 + 8'(n_tx);
					n_tx++;
				end
				nb++;
			end
			// Hold the old level well past the falling edge
			#380;
			if (bitn == 8)
				sda_oe = !rd && (nb != 0 || sh[7:1] == OWN_ADDR);
			else
				sda_oe = tx_on && bitn >= 0 && !tx[7 - bitn];
		end
endmodule : lpic_slave
`default_nettype wire

/* File: tb/lpic_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module lpic_top_test;
	import lpic_pkg::*;
	logic clk, rst, wr_s, rd_s, scl_hold, sda_pull;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [3:0] route, pin_in;
	wire logic [31:0] rdata;
	wire logic [3:0] pin_out, pin_oe;
	wire logic slv_oe;
	wire logic scl_w = !pin_oe[route[1:0]] && !scl_hold;
	wire logic sda_w = !pin_oe[route[3:2]] && !slv_oe && !sda_pull;
	int n_errors = 0;
	int samples_checked = 0;
	logic [11:0] ra [8] = '{OFS_SCL_LOW, OFS_SCL_HIGH, OFS_SDA_DUTY, OFS_START_WAIT,
		OFS_STOP_WAIT, OFS_TIMEOUT, OFS_PIN_ROUTE, OFS_CTRL};
	logic [31:0] rv [8] = '{32'h28, 32'h28, 32'h10, 32'h1e, 32'h2c, 32'hc8, 32'h4, 32'h0};
	logic [31:0] cv [8] = '{32'h2a, 32'h8, 32'h3, 32'h5, 32'h6, 32'hc8, 32'h4, 32'h0};
	always_comb
	begin
		pin_in = 4'hf;
		pin_in[route[1:0]] = scl_w;
		pin_in[route[3:2]] = sda_w;
	end
	lpic_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
	lpic_slave slv (.scl(scl_w), .sda(sda_w), .sda_oe(slv_oe));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic conclude();
		$display("Checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v & m, e);
	endtask : rdc
	task automatic wait_bit(input logic [11:0] a, input int b, input logic val = 1'b1);
		logic [31:0] v;
		int k;
		for (k = 0; k < 3000; k++)
		begin
			rd(a, v);
			if (v[b] === val)
				break;
		end
		chk(32'(k < 3000), 32'h1);
		if (k == 3000)
			conclude();
	endtask : wait_bit
	// Run flag low, then let the last STOP events settle
	task automatic wait_idle();
		wait_bit(OFS_STATUS, 1, 1'b0);
		repeat (8) @(posedge clk);
	endtask : wait_idle
	task automatic go(input logic [7:0] d);
		wr(OFS_XFER_CTRL, {5'h0, d, 8'h5c, 11'h0});
		wr(OFS_XFER_CTRL, {3'h0, 2'h3, d, 8'h5c, 11'h0});
	endtask : go
	task automatic wait_start();
		int k;
		for (k = 0; k < 500 && pin_oe[route[3:2]] !== 1'b1; k++)
			@(posedge clk);
		chk(32'(k < 500), 32'h1);
		if (k == 500)
			conclude();
	endtask : wait_start
	task automatic cmpq(input logic [63:0] e, input int n);
		chk(32'(slv.rxq.size()), 32'(n));
		for (int i = 0; i < n && i < slv.rxq.size(); i++)
			chk({24'h0, slv.rxq[i]}, {24'h0, e[8 * (n - 1 - i) +: 8]});
		slv.rxq.delete();
	endtask : cmpq
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		rst = 1'b1;
		addr = 12'h0;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		scl_hold = 1'b0;
		sda_pull = 1'b0;
		route = 4'h4;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rdc(ra[i], 32'hffffffff, rv[i]);
		rdc(12'h0fc, 32'hffffffff, 32'h0);
		for (int i = 0; i < 7; i++)
			wr(ra[i], cv[i]);
		wr(OFS_TGT0, {14'h0, 7'h2a, 4'h0, 7'h33});
		wr(OFS_EVT_ENA, 32'h3f6);
		wr(OFS_CMD0, 32'h001);
		wr(OFS_CMD0 + 12'h004, 32'h001);
		go(8'h11);
		repeat (200) @(posedge clk);
		rdc(OFS_CMD0, 32'h80000000, 32'h0);
		wr(OFS_CTRL, 32'h1);
		go(8'h11);
		wait_bit(OFS_CMD0, 31);
		wr(OFS_XFER_CTRL, {3'h0, 2'h3, 8'h22, 8'h5c, 11'h0});
		wait_bit(OFS_CMD0 + 12'h004, 31);
		cmpq(64'h545c5411545c5422, 8);
		wait_idle();
		rdc(OFS_EVT_ST, 32'h318, 32'h310);
		rdc(OFS_EVT_RAW, 32'h4, 32'h4);
		wr(OFS_EVT_CLR, 32'h3fe);
		rdc(OFS_EVT_RAW, 32'hffffffff, 32'h0);
		wr(OFS_PIN_ROUTE, 32'he);
		route <= 4'he;
		wr(OFS_CMD0, 32'h0);
		wr(OFS_CMD0 + 12'h004, 32'h0);
		wr(OFS_CMD0 + 12'h008, 32'h002);
		go(8'h0);
		wait_bit(OFS_EVT_RAW, 6);
		rdc(OFS_RDATA, 32'hff, 32'ha5);
		wr(OFS_EVT_CLR, 32'h80);
		wait_bit(OFS_EVT_RAW, 6);
		rdc(OFS_RDATA, 32'hff, 32'ha6);
		wait_bit(OFS_CMD0 + 12'h008, 31);
		cmpq(64'h545c55, 3);
		chk(32'(slv.n_tx), 32'h2);
		wait_idle();
		wr(OFS_EVT_CLR, 32'h3fe);
		wr(OFS_CMD0 + 12'h008, 32'h0);
		wr(OFS_CMD0 + 12'h00c, 32'h101);
		go(8'h0);
		wait_bit(OFS_EVT_RAW, 5);
		wait_idle();
		rdc(OFS_EVT_RAW, 32'h4, 32'h4);
		wr(OFS_CMD0 + 12'h00c, 32'h0);
		wr(OFS_CMD0 + 12'h010, 32'h001);
		go(8'h0);
		wait_start();
		sda_pull <= 1'b1;
		wait_bit(OFS_EVT_RAW, 1);
		chk({28'h0, pin_oe}, 32'h0);
		sda_pull <= 1'b0;
		wr(OFS_TIMEOUT, 32'd60);
		go(8'h0);
		wait_start();
		scl_hold <= 1'b1;
		wait_bit(OFS_EVT_RAW, 4);
		chk({28'h0, pin_oe}, 32'h0);
		scl_hold <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc(OFS_SCL_LOW, 32'hffffffff, 32'h28);
		rdc(OFS_TIMEOUT, 32'hffffffff, 32'hc8);
		conclude();
	end
endmodule : lpic_top_test
`default_nettype wire
